// file: src/alu_exec_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] unsigned 8-bit add, add with carry, subtract with borrow
// [RULE2] bitwise AND, OR, XOR and complement on 8-bit operands
// [RULE3] rotate, swap, clear, complement, decimal adjust act on main register only
// [RULE4] operands from main, secondary or outside; results to main or out
// [RULE5] carry, overflow, parity held in program status flags register
// [RULE6] legacy opcode encodings and effects kept; only cycle counts differ
// [RULE7] add from register one cycle; direct, indirect, immediate two cycles
// [RULE8] subtract from register one cycle; other sources two cycles
// [RULE9] inc/dec main one, register two, memory three; pointer increment one
// [RULE10] multiply and divide take five cycles, one byte each
// [RULE11] AND: register 1, sources 2, to direct 3, immediate-to-direct 4
// [RULE12] OR: register 1, sources 2, to direct 3, immediate-to-direct 4
// [RULE13] XOR: register 1, sources 2, to direct 3, immediate-to-direct 4
// [RULE14] all four rotates complete in one cycle
// [RULE15] swap, clear, complement of main register take one cycle
// [RULE16] move to main: register 1, direct, indirect, immediate 2
// [RULE17] move to register: from main 2, from direct 4, immediate 2
// [RULE18] move to direct: from main or register 3, from memory 4
// [RULE19] one instruction cycle is exactly one core clock period
// [RULE20] flags updated as legacy; parity always follows main register
// [RULE21] product/quotient low to main, high/remainder to secondary; zero divisor flags overflow
module alu_exec_unit (
  input  wire logic        mclk,                        // core clock
  input  wire logic        resetn,                      // async reset, active low
  input  wire logic        start,                       // issue opcode this cycle
  input  wire logic [7:0]  opcode,                      // instruction opcode
  input  wire logic [7:0]  src_data,                    // operand fetched outside
  input  wire logic [7:0]  dst_data,                    // current value of target location
  input  wire logic        sfr_wr,                      // direct write of a register
  input  wire logic [2:0]  sfr_sel,                     // which register sfr_wr hits
  input  wire logic [7:0]  sfr_wdata,                   // data for sfr_wr
  output logic             ready,                       // can take start
  output logic             done,                        // instruction retired
  output logic             result_wr,                   // result_data to be stored
  output logic      [7:0]  result_data,                 // result driven out
  output logic      [7:0]  main_operand_register,       // main operand register
  output logic      [7:0]  secondary_operand_register,  // secondary operand register
  output logic      [7:0]  program_status_flags,        // flags incl. live parity
  output logic      [15:0] data_pointer                 // 16-bit data pointer
);

  typedef enum logic {PH_IDLE, PH_EXEC} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [2:0]  cnt;
    logic [7:0]  main;
    logic [7:0]  sec;
    logic [7:0]  flags;
    logic [15:0] ptr;
    logic [7:0]  n_main;
    logic [7:0]  n_sec;
    logic [7:0]  n_flags;
    logic [15:0] n_ptr;
    logic [7:0]  n_out;
    logic        n_out_wr;
    logic [7:0]  out;
    logic        out_wr;
    logic        done;
  } state_t;

  state_t s_q;
  state_t s_d;

  // cycles each opcode occupies
  function automatic logic [2:0] cycles_of(input logic [7:0] op);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = op[7:4];
    lo = op[3:0];
    cycles_of = alu_pkg::CYC_ONE;
    unique case (hi)
      alu_pkg::ROW_ADD, alu_pkg::ROW_ADC, alu_pkg::ROW_SBB,
      alu_pkg::ROW_OR, alu_pkg::ROW_AND, alu_pkg::ROW_XOR: begin
        if (lo[3])
          cycles_of = alu_pkg::CYC_ONE; // [RULE7] [RULE8] [RULE11]
        else if (lo >= alu_pkg::LO_IMM)
          cycles_of = alu_pkg::CYC_TWO; // [RULE7] [RULE8] [RULE12]
        else if (hi inside {alu_pkg::ROW_ADD, alu_pkg::ROW_ADC, alu_pkg::ROW_SBB})
          cycles_of = alu_pkg::CYC_ONE; // [RULE14]
        else if (lo == alu_pkg::LO_DIR_A)
          cycles_of = alu_pkg::CYC_THREE; // [RULE11] [RULE12] [RULE13]
        else if (lo == alu_pkg::LO_DIR_IMM)
          cycles_of = alu_pkg::CYC_FOUR; // [RULE11] [RULE12] [RULE13]
      end
      alu_pkg::ROW_INC, alu_pkg::ROW_DEC: begin
        if (lo[3])
          cycles_of = alu_pkg::CYC_TWO; // [RULE9]
        else if (lo >= alu_pkg::LO_DIR && lo <= 4'h7)
          cycles_of = alu_pkg::CYC_THREE; // [RULE9]
      end
      default: begin
        if (op == alu_pkg::OP_MUL || op == alu_pkg::OP_DIV)
          cycles_of = alu_pkg::CYC_FIVE; // [RULE10]
        else if (op == alu_pkg::OP_MOV_A_IMM || op == alu_pkg::OP_MOV_A_DIR
                 || op == 8'hE6 || op == 8'hE7)
          cycles_of = alu_pkg::CYC_TWO; // [RULE16]
        else if (hi == 4'hF && lo[3])
          cycles_of = alu_pkg::CYC_TWO; // [RULE17]
        else if (hi == 4'hA && lo[3])
          cycles_of = alu_pkg::CYC_FOUR; // [RULE17]
        else if (hi == 4'h7 && lo[3])
          cycles_of = alu_pkg::CYC_TWO; // [RULE17]
        else if (op == alu_pkg::OP_MOV_DIR_A || (hi == 4'h8 && lo[3]))
          cycles_of = alu_pkg::CYC_THREE; // [RULE18]
        else if (op == alu_pkg::OP_MOV_DD || op == 8'h86 || op == 8'h87)
          cycles_of = alu_pkg::CYC_FOUR; // [RULE18]
      end
    endcase
  endfunction

  // 8-bit add with carry-in; returns {cy, ac, ov, sum}
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic ci);
    logic [4:0] lo;
    logic [7:0] low7;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    low7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
    full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    add8 = {full[8], lo[4], full[8] ^ low7[7], full[7:0]};
  endfunction

  // 8-bit subtract with borrow; returns {cy, ac, ov, diff}
  function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                       input logic bi);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bi};
    full = {1'b0, a} - {1'b0, b} - {8'h00, bi};
    sub8 = {full[8], lo[4], (a[7] ^ b[7]) & (full[7] ^ a[7]), full[7:0]};
  endfunction

  logic [15:0] mul_product;
  logic [7:0]  div_quot;
  logic [7:0]  div_rem;
  logic        div_zero;

  mul_div_unit #(
    .W (alu_pkg::DATA_W)
  ) u_mul_div (
    .a         (s_q.main),
    .b         (s_q.sec),
    .product   (mul_product),
    .quotient  (div_quot),
    .remainder (div_rem),
    .div_zero  (div_zero)
  );

  // effect of the opcode presented now
  logic [7:0]  r_main;
  logic [7:0]  r_sec;
  logic [7:0]  r_flags;
  logic [15:0] r_ptr;
  logic [7:0]  r_out;
  logic        r_out_wr;
  logic [10:0] arith;
  logic [7:0]  lhs;
  logic [7:0]  rhs;
  logic [7:0]  logic_res;
  logic [8:0]  bcd;
  logic        bcd_cy;
  logic [3:0]  op_hi;
  logic [3:0]  op_lo;
  logic        cy;

  always_comb begin
    r_main    = s_q.main;
    r_sec     = s_q.sec;
    r_flags   = s_q.flags;
    r_ptr     = s_q.ptr;
    r_out     = 8'h00;
    r_out_wr  = 1'b0;
    arith     = 11'h000;
    logic_res = 8'h00;
    bcd       = 9'h000;
    bcd_cy    = 1'b0;
    op_hi     = opcode[7:4];
    op_lo     = opcode[3:0];
    cy        = s_q.flags[alu_pkg::FLAG_CY];
    // memory forms take the location as left side, main register forms take main
    lhs = (op_lo == alu_pkg::LO_DIR_A || op_lo == alu_pkg::LO_DIR_IMM) ? dst_data : s_q.main;
    rhs = (op_lo == alu_pkg::LO_DIR_A) ? s_q.main : src_data;           // [RULE4]
    unique case (op_hi)
      alu_pkg::ROW_ADD, alu_pkg::ROW_ADC, alu_pkg::ROW_SBB: begin
        if (op_lo >= alu_pkg::LO_IMM) begin
          if (op_hi == alu_pkg::ROW_SBB)
            arith = sub8(s_q.main, src_data, cy);                        // [RULE1]
          else
            arith = add8(s_q.main, src_data, (op_hi == alu_pkg::ROW_ADC) & cy); // [RULE1]
          r_main                   = arith[7:0];
          r_flags[alu_pkg::FLAG_CY] = arith[10];                         // [RULE20] [RULE5]
          r_flags[alu_pkg::FLAG_AC] = arith[9];
          r_flags[alu_pkg::FLAG_OV] = arith[8];
        end else if (opcode == alu_pkg::OP_RL) begin
          r_main = {s_q.main[6:0], s_q.main[7]}; // [RULE14] [RULE3]
        end else if (opcode == alu_pkg::OP_RLC) begin
          r_main                    = {s_q.main[6:0], cy}; // [RULE14] [RULE3]
          r_flags[alu_pkg::FLAG_CY] = s_q.main[7];
        end
      end
      alu_pkg::ROW_OR, alu_pkg::ROW_AND, alu_pkg::ROW_XOR: begin
        if (op_lo >= alu_pkg::LO_DIR_A) begin
          if (op_hi == alu_pkg::ROW_OR)
            logic_res = lhs | rhs;                                       // [RULE2]
          else if (op_hi == alu_pkg::ROW_AND)
            logic_res = lhs & rhs;                                       // [RULE2]
          else
            logic_res = lhs ^ rhs;                                       // [RULE2]
          if (op_lo == alu_pkg::LO_DIR_A || op_lo == alu_pkg::LO_DIR_IMM) begin
            r_out    = logic_res;                                        // [RULE4]
            r_out_wr = 1'b1;
          end else begin
            r_main = logic_res;
          end
        end
      end
      alu_pkg::ROW_INC, alu_pkg::ROW_DEC: begin
        if (op_lo == alu_pkg::LO_IMM) begin
          r_main = (op_hi == alu_pkg::ROW_INC) ? s_q.main + 8'h01 : s_q.main - 8'h01; // [RULE9]
        end else if (op_lo >= alu_pkg::LO_DIR) begin
          r_out    = (op_hi == alu_pkg::ROW_INC) ? src_data + 8'h01 : src_data - 8'h01;
          r_out_wr = 1'b1;                                               // [RULE4]
        end else if (op_lo == 4'h3) begin
          // rotates: main register only
          unique case (opcode)
            alu_pkg::OP_RR: r_main = {s_q.main[0], s_q.main[7:1]};       // [RULE14] [RULE3]
            alu_pkg::OP_RRC: begin
              r_main                    = {cy, s_q.main[7:1]};           // [RULE14] [RULE3]
              r_flags[alu_pkg::FLAG_CY] = s_q.main[0];
            end
            default: ;
          endcase
        end
      end
      default: begin
        unique case (1'b1)
          opcode == alu_pkg::OP_SWAP:
            r_main = {s_q.main[3:0], s_q.main[7:4]};                     // [RULE15] [RULE3]
          opcode == alu_pkg::OP_CLR:
            r_main = 8'h00;                                              // [RULE15] [RULE3]
          opcode == alu_pkg::OP_CPL:
            r_main = ~s_q.main;                                          // [RULE15] [RULE2]
          opcode == alu_pkg::OP_DA: begin
            bcd = {1'b0, s_q.main};
            if (bcd[3:0] > alu_pkg::BCD_MAX || s_q.flags[alu_pkg::FLAG_AC])
              bcd = bcd + alu_pkg::BCD_LO_FIX;
            bcd_cy = cy | bcd[8];
            if (bcd[7:4] > alu_pkg::BCD_MAX || bcd_cy)
              bcd = {1'b0, bcd[7:0]} + alu_pkg::BCD_HI_FIX;
            r_main                    = bcd[7:0];                        // [RULE3]
            r_flags[alu_pkg::FLAG_CY] = bcd_cy | bcd[8];                 // [RULE20]
          end
          opcode == alu_pkg::OP_MUL: begin
            r_main                    = mul_product[7:0];                // [RULE21]
            r_sec                     = mul_product[15:8];
            r_flags[alu_pkg::FLAG_CY] = 1'b0;                            // [RULE20]
            r_flags[alu_pkg::FLAG_OV] = (mul_product[15:8] != 8'h00);
          end
          opcode == alu_pkg::OP_DIV: begin
            if (!div_zero) begin
              r_main = div_quot;                                         // [RULE21]
              r_sec  = div_rem;
            end
            r_flags[alu_pkg::FLAG_CY] = 1'b0;                            // [RULE20]
            r_flags[alu_pkg::FLAG_OV] = div_zero;                        // [RULE21]
          end
          opcode == alu_pkg::OP_INC_PTR:
            r_ptr = s_q.ptr + 16'h0001; // [RULE9]
          opcode == alu_pkg::OP_MOV_A_IMM || opcode == alu_pkg::OP_MOV_A_DIR
            || opcode == 8'hE6 || opcode == 8'hE7 || (op_hi == 4'hE && op_lo[3]):
            r_main = src_data;                                           // [RULE16]
          (op_hi == 4'hF && op_lo[3]) || opcode == alu_pkg::OP_MOV_DIR_A: begin
            r_out    = s_q.main;                                         // [RULE17] [RULE18]
            r_out_wr = 1'b1;
          end
          (op_hi == 4'hA && op_lo[3]) || (op_hi == 4'h7 && op_lo[3])
            || (op_hi == 4'h8 && op_lo[3]) || opcode == alu_pkg::OP_MOV_DD
            || opcode == 8'h86 || opcode == 8'h87: begin
            r_out    = src_data;                                         // [RULE17] [RULE18]
            r_out_wr = 1'b1;
          end
          default: ;
        endcase
      end
    endcase
  end

  // sequencing: an N-cycle opcode retires at the edge ending its Nth clock
  always_comb begin
    s_d        = s_q;
    s_d.done   = 1'b0;
    s_d.out_wr = 1'b0;
    unique case (s_q.phase)
      PH_IDLE: begin
        if (start) begin
          if (cycles_of(opcode) == alu_pkg::CYC_ONE) begin
            s_d.main   = r_main;                                         // [RULE19] [RULE6]
            s_d.sec    = r_sec;
            s_d.flags  = r_flags;
            s_d.ptr    = r_ptr;
            s_d.out    = r_out;
            s_d.out_wr = r_out_wr;
            s_d.done   = 1'b1;
          end else begin
            s_d.phase    = PH_EXEC;
            s_d.cnt      = cycles_of(opcode) - alu_pkg::CYC_ONE;         // [RULE19]
            s_d.n_main   = r_main;
            s_d.n_sec    = r_sec;
            s_d.n_flags  = r_flags;
            s_d.n_ptr    = r_ptr;
            s_d.n_out    = r_out;
            s_d.n_out_wr = r_out_wr;
          end
        end else if (sfr_wr) begin
          unique case (sfr_sel)
            alu_pkg::SEL_MAIN:  s_d.main       = sfr_wdata;
            alu_pkg::SEL_SEC:   s_d.sec        = sfr_wdata;
            alu_pkg::SEL_FLAGS: s_d.flags      = sfr_wdata;              // [RULE5]
            alu_pkg::SEL_DPL:   s_d.ptr[7:0]   = sfr_wdata;
            alu_pkg::SEL_DPH:   s_d.ptr[15:8]  = sfr_wdata;
            default: ;
          endcase
        end
      end
      PH_EXEC: begin
        s_d.cnt = s_q.cnt - alu_pkg::CYC_ONE;
        if (s_q.cnt == alu_pkg::CYC_ONE) begin
          s_d.phase  = PH_IDLE;
          s_d.main   = s_q.n_main;                                       // [RULE19]
          s_d.sec    = s_q.n_sec;
          s_d.flags  = s_q.n_flags;
          s_d.ptr    = s_q.n_ptr;
          s_d.out    = s_q.n_out;
          s_d.out_wr = s_q.n_out_wr;
          s_d.done   = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q          <= '0;
      s_q.phase    <= PH_IDLE;
      s_q.main     <= alu_pkg::MAIN_RST;
      s_q.sec      <= alu_pkg::SEC_RST;
      s_q.flags    <= alu_pkg::FLAGS_RST;
      s_q.ptr      <= alu_pkg::PTR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign ready                      = (s_q.phase == PH_IDLE);
  assign done                       = s_q.done;
  assign result_wr                  = s_q.out_wr;
  assign result_data                = s_q.out;
  assign main_operand_register      = s_q.main;
  assign secondary_operand_register = s_q.sec;
  assign data_pointer               = s_q.ptr;
  // parity is live from the main register
  assign program_status_flags = {s_q.flags[7:1], ^s_q.main};             // [RULE20] [RULE5]

endmodule

// file: src/alu_pkg.sv
package alu_pkg;

  // widths
  localparam int unsigned DATA_W = 8;

  // cycle counts
  localparam logic [2:0] CYC_ONE   = 3'h1;
  localparam logic [2:0] CYC_TWO   = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR  = 3'h4;
  localparam logic [2:0] CYC_FIVE  = 3'h5;

  // flag positions in the program status flags
  localparam int unsigned FLAG_CY = 7;
  localparam int unsigned FLAG_AC = 6;
  localparam int unsigned FLAG_OV = 2;
  localparam int unsigned FLAG_P  = 0;

  // reset values
  localparam logic [7:0]  MAIN_RST  = 8'h00;
  localparam logic [7:0]  SEC_RST   = 8'h00;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] PTR_RST   = 16'h0000;

  // register write select
  localparam logic [2:0] SEL_MAIN  = 3'h0;
  localparam logic [2:0] SEL_SEC   = 3'h1;
  localparam logic [2:0] SEL_FLAGS = 3'h2;
  localparam logic [2:0] SEL_DPL   = 3'h3;
  localparam logic [2:0] SEL_DPH   = 3'h4;

  // opcode row (upper nibble) groups
  localparam logic [3:0] ROW_INC  = 4'h0;
  localparam logic [3:0] ROW_DEC  = 4'h1;
  localparam logic [3:0] ROW_ADD  = 4'h2;
  localparam logic [3:0] ROW_ADC  = 4'h3;
  localparam logic [3:0] ROW_OR   = 4'h4;
  localparam logic [3:0] ROW_AND  = 4'h5;
  localparam logic [3:0] ROW_XOR  = 4'h6;
  localparam logic [3:0] ROW_SBB  = 4'h9;

  // single opcodes
  localparam logic [7:0] OP_RR        = 8'h03;
  localparam logic [7:0] OP_RRC       = 8'h13;
  localparam logic [7:0] OP_RL        = 8'h23;
  localparam logic [7:0] OP_RLC       = 8'h33;
  localparam logic [7:0] OP_MOV_A_IMM = 8'h74;
  localparam logic [7:0] OP_DIV       = 8'h84;
  localparam logic [7:0] OP_MOV_DD    = 8'h85;
  localparam logic [7:0] OP_INC_PTR   = 8'hA3;
  localparam logic [7:0] OP_MUL       = 8'hA4;
  localparam logic [7:0] OP_SWAP      = 8'hC4;
  localparam logic [7:0] OP_DA        = 8'hD4;
  localparam logic [7:0] OP_CLR       = 8'hE4;
  localparam logic [7:0] OP_MOV_A_DIR = 8'hE5;
  localparam logic [7:0] OP_CPL       = 8'hF4;
  localparam logic [7:0] OP_MOV_DIR_A = 8'hF5;

  // low nibble source forms
  localparam logic [3:0] LO_DIR_A   = 4'h2;
  localparam logic [3:0] LO_DIR_IMM = 4'h3;
  localparam logic [3:0] LO_IMM     = 4'h4;
  localparam logic [3:0] LO_DIR     = 4'h5;

  // decimal correction
  localparam logic [3:0] BCD_MAX     = 4'h9;
  localparam logic [8:0] BCD_LO_FIX  = 9'h006;
  localparam logic [8:0] BCD_HI_FIX  = 9'h060;

endpackage

// file: src/mul_div_unit.sv
`timescale 1ns/1ps
module mul_div_unit #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0]   a,          // main operand
  input  wire logic [W-1:0]   b,          // secondary operand
  output logic      [2*W-1:0] product,    // a times b
  output logic      [W-1:0]   quotient,   // a over b
  output logic      [W-1:0]   remainder,  // a modulo b
  output logic                div_zero    // b is zero
);

  always_comb begin
    product  = a * b;
    div_zero = (b == '0);
    // zero divisor: caller keeps its registers
    quotient  = div_zero ? '0 : a / b;
    remainder = div_zero ? '0 : a % b;
  end

endmodule

// file: tb/alu_exec_unit_props.sv
`timescale 1ns/1ps
module alu_exec_unit_props (
  input wire logic        mclk,                       // clock
  input wire logic        resetn,                     // reset
  input wire logic        start,                      // issue
  input wire logic [7:0]  opcode,                     // opcode
  input wire logic [7:0]  src_data,                   // operand
  input wire logic [7:0]  dst_data,                   // target value
  input wire logic        sfr_wr,                     // reg write
  input wire logic [2:0]  sfr_sel,                    // reg select
  input wire logic [7:0]  sfr_wdata,                  // reg data
  input wire logic        ready,                      // idle
  input wire logic        done,                       // retired
  input wire logic        result_wr,                  // store
  input wire logic [7:0]  result_data,                // result
  input wire logic [7:0]  main_operand_register,      // main
  input wire logic [7:0]  secondary_operand_register, // secondary
  input wire logic [7:0]  program_status_flags,       // flags
  input wire logic [15:0] data_pointer                // pointer
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic tk;
  assign tk = start && ready;
  property p_reg_one; tk && opcode inside {[8'h28:8'h2F]} |=> done; endproperty
  a_reg_one: assert property (p_reg_one) else $error("register add not one cycle");
  property p_imm_two; tk && opcode == 8'h94 |=> !done ##1 done; endproperty
  a_imm_two: assert property (p_imm_two) else $error("immediate subtract timing");
  property p_mul_five; tk && opcode == 8'hA4 |=> !ready [*4] ##1 done; endproperty
  a_mul_five: assert property (p_mul_five) else $error("multiply latency wrong");
  property p_mul_res;
    tk && opcode == 8'hA4 |-> ##5 {secondary_operand_register, main_operand_register} ==
      {8'h00, $past(main_operand_register, 5)} * {8'h00, $past(secondary_operand_register, 5)};
  endproperty
  a_mul_res: assert property (p_mul_res) else $error("product placement wrong");
  property p_and_dir; tk && opcode == 8'h53 |=> !done [*3] ##1 (done && result_wr); endproperty
  a_and_dir: assert property (p_and_dir) else $error("and to direct timing");
  property p_parity; program_status_flags[0] == ^main_operand_register; endproperty
  a_parity: assert property (p_parity) else $error("parity does not follow main");
  property p_clr; tk && opcode == 8'hE4 |=> done && main_operand_register == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("clear failed");
  property p_rl;
    tk && opcode == 8'h23 |=> main_operand_register ==
      {$past(main_operand_register[6:0]), $past(main_operand_register[7])};
  endproperty
  a_rl: assert property (p_rl) else $error("rotate left wrong");
  property p_mov_rn;
    tk && opcode inside {[8'hE8:8'hEF]} |=> done && main_operand_register == $past(src_data);
  endproperty
  a_mov_rn: assert property (p_mov_rn) else $error("register move wrong");
  c_mul: cover property (tk && opcode == 8'hA4);
  c_store: cover property (done && result_wr);
  c_b2b: cover property (done && tk);
endmodule

// file: tb/core_ctrl_model.sv
`timescale 1ns/1ps
module core_ctrl_model (
  input  wire logic       mclk,      // core clock
  input  wire logic       done,      // retire pulse
  output logic            start,     // issue strobe
  output logic      [7:0] opcode,    // instruction
  output logic      [7:0] src_data,  // fetched operand
  output logic      [7:0] dst_data,  // target location value
  output logic            sfr_wr,    // register write
  output logic      [2:0] sfr_sel,   // register select
  output logic      [7:0] sfr_wdata  // register data
);
  initial {start, opcode, src_data, dst_data, sfr_wr, sfr_sel, sfr_wdata} = '0;
  task automatic wr_reg(input logic [2:0] s, input logic [7:0] v);
    @(posedge mclk);
    #1;
    sfr_wr = 1'b1;
    sfr_sel = s;
    sfr_wdata = v;
    @(posedge mclk);
    #1;
    sfr_wr = 1'b0;
    sfr_wdata = ~v;
  endtask
  // now: raise start in the current done cycle, back to back
  task automatic issue(input logic now, input logic [7:0] op, s, d, output int n);
    if (!now) begin
      @(posedge mclk);
      #1;
    end
    start = 1'b1;
    opcode = op;
    src_data = s;
    dst_data = d;
    @(posedge mclk);
    #1;
    start = 1'b0;
    src_data = ~s;
    dst_data = ~d;
    n = 1;
    while (done !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
endmodule

// file: tb/mcu_alu_and_instruction_timing_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module mcu_alu_and_instruction_timing_tb_top;
  typedef struct {
    logic [7:0] op, a, b, src, dst;
    logic       ci;
    int         cyc;
    logic [7:0] em, es, er;
    logic       ewr, ecy;
  } row_t;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        start, sfr_wr, ready, done, result_wr;
  logic [7:0]  opcode, src_data, dst_data, sfr_wdata, result_data;
  logic [2:0]  sfr_sel;
  logic [7:0]  main_operand_register, secondary_operand_register, program_status_flags;
  logic [15:0] data_pointer;
  int          err_count = 0;
  int          checked = 0;
  int          n;
  row_t        rows [22] = '{
    '{8'h28,8'h3C,8'h00,8'h05,8'h00,1'b0,1,8'h41,8'h00,8'h00,1'b0,1'b0},
    '{8'h34,8'h10,8'h00,8'h0F,8'h00,1'b1,2,8'h20,8'h00,8'h00,1'b0,1'b0},
    '{8'h94,8'h10,8'h00,8'h20,8'h00,1'b0,2,8'hF0,8'h00,8'h00,1'b0,1'b1},
    '{8'h98,8'h10,8'h00,8'h05,8'h00,1'b1,1,8'h0A,8'h00,8'h00,1'b0,1'b0},
    '{8'h04,8'hFF,8'h00,8'h00,8'h00,1'b1,1,8'h00,8'h00,8'h00,1'b0,1'b1},
    '{8'h15,8'h33,8'h00,8'h40,8'h00,1'b0,3,8'h33,8'h00,8'h3F,1'b1,1'b0},
    '{8'hA4,8'h50,8'hA0,8'h00,8'h00,1'b1,5,8'h00,8'h32,8'h00,1'b0,1'b0},
    '{8'h84,8'hFB,8'h12,8'h00,8'h00,1'b1,5,8'h0D,8'h11,8'h00,1'b0,1'b0},
    '{8'hD4,8'h9A,8'h00,8'h00,8'h00,1'b0,1,8'h00,8'h00,8'h00,1'b0,1'b1},
    '{8'h53,8'h5A,8'h00,8'h0F,8'h3C,1'b0,4,8'h5A,8'h00,8'h0C,1'b1,1'b0},
    '{8'h58,8'hF0,8'h00,8'h3C,8'h00,1'b0,1,8'h30,8'h00,8'h00,1'b0,1'b0},
    '{8'h42,8'h0F,8'h00,8'h00,8'h30,1'b0,3,8'h0F,8'h00,8'h3F,1'b1,1'b0},
    '{8'h63,8'h5A,8'h00,8'hFF,8'h0F,1'b0,4,8'h5A,8'h00,8'hF0,1'b1,1'b0},
    '{8'h33,8'h80,8'h00,8'h00,8'h00,1'b1,1,8'h01,8'h00,8'h00,1'b0,1'b1},
    '{8'h13,8'h01,8'h00,8'h00,8'h00,1'b0,1,8'h00,8'h00,8'h00,1'b0,1'b1},
    '{8'h23,8'h81,8'h00,8'h00,8'h00,1'b0,1,8'h03,8'h00,8'h00,1'b0,1'b0},
    '{8'hC4,8'hA5,8'h00,8'h00,8'h00,1'b0,1,8'h5A,8'h00,8'h00,1'b0,1'b0},
    '{8'hE4,8'hA5,8'h00,8'h00,8'h00,1'b0,1,8'h00,8'h00,8'h00,1'b0,1'b0},
    '{8'hF4,8'hA5,8'h00,8'h00,8'h00,1'b0,1,8'h5A,8'h00,8'h00,1'b0,1'b0},
    '{8'hE8,8'h11,8'h00,8'h77,8'h00,1'b0,1,8'h77,8'h00,8'h00,1'b0,1'b0},
    '{8'hA8,8'h11,8'h00,8'h21,8'h00,1'b0,4,8'h11,8'h00,8'h21,1'b1,1'b0},
    '{8'h85,8'h11,8'h00,8'h2A,8'h00,1'b0,4,8'h11,8'h00,8'h2A,1'b1,1'b0}
  };
  always #2 mclk = ~mclk;
  alu_exec_unit u_alu_exec_unit (.mclk, .resetn, .start, .opcode, .src_data, .dst_data,
    .sfr_wr, .sfr_sel, .sfr_wdata, .ready, .done, .result_wr, .result_data,
    .main_operand_register, .secondary_operand_register, .program_status_flags, .data_pointer);
  core_ctrl_model u_core_ctrl_model (.mclk, .done, .start, .opcode, .src_data, .dst_data,
    .sfr_wr, .sfr_sel, .sfr_wdata);
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic run(input logic now, input logic [7:0] op, s, d);
    u_core_ctrl_model.issue(now, op, s, d, n);
    if (n >= 20) begin
      err_count++;
      report_and_stop();
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #1 resetn = 1'b1;
    foreach (rows[i]) begin
      u_core_ctrl_model.wr_reg(3'h0, rows[i].a);
      u_core_ctrl_model.wr_reg(3'h1, rows[i].b);
      u_core_ctrl_model.wr_reg(3'h2, {rows[i].ci, 7'h00});
      run(1'b0, rows[i].op, rows[i].src, rows[i].dst);
      `CHK("cycles", rows[i].cyc, n)
      `CHK("main", rows[i].em, main_operand_register)
      `CHK("secondary", rows[i].es, secondary_operand_register)
      `CHK("carry", rows[i].ecy, program_status_flags[7])
      `CHK("parity", ^rows[i].em, program_status_flags[0])
      `CHK("store", rows[i].ewr, result_wr)
      if (rows[i].ewr) `CHK("result", rows[i].er, result_data)
      $display("row %0d done", i);
    end
    @(posedge mclk);
    #1 resetn = 1'b0;
    repeat (2) @(posedge mclk);
    `CHK("reset main", 8'h00, main_operand_register)
    `CHK("reset flags", 8'h00, program_status_flags)
    `CHK("reset ready", 1'b1, ready)
    #1 resetn = 1'b1;
    $display("reset done");
    run(1'b0, 8'h04, 8'h00, 8'h00);
    run(1'b1, 8'h04, 8'h00, 8'h00);
    `CHK("back to back cycles", 1, n)
    `CHK("back to back main", 8'h02, main_operand_register)
    $display("back to back done");
    u_core_ctrl_model.wr_reg(3'h0, 8'h37);
    u_core_ctrl_model.wr_reg(3'h1, 8'h00);
    run(1'b0, 8'h84, 8'h00, 8'h00);
    `CHK("zero divide cycles", 5, n)
    `CHK("zero divide main", 8'h37, main_operand_register)
    `CHK("zero divide overflow", 1'b1, program_status_flags[2])
    $display("zero divide done");
    run(1'b0, 8'hA3, 8'h00, 8'h00);
    `CHK("pointer", 16'h0001, data_pointer)
    report_and_stop();
  end
endmodule
bind alu_exec_unit alu_exec_unit_props u_props (.mclk, .resetn, .start, .opcode, .src_data,
  .dst_data, .sfr_wr, .sfr_sel, .sfr_wdata, .ready, .done, .result_wr, .result_data,
  .main_operand_register, .secondary_operand_register, .program_status_flags, .data_pointer);
